/* File: core/fwqs_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - Chip erase opcodes C7h or 60h erase the whole array if the latch is set.
// - Chip erase starts only when chip select rises right after the opcode.
// - Opcode 06h sets the write-enable latch.
// - The write-enable latch is cleared at power-up reset.
// - Every erase, program and register write needs the latch set first.
// - The latch clears itself when any write, program or erase finishes.
// - Opcode 04h clears the write-enable latch.
// - Opcode 05h returns status, also while an operation runs.
// - Opcode 01h writes block protect, status write protect and quad I/O enable.
// - Opcode 48h returns the function register.
// - Opcode 42h sets bottom area and info row locks; only reset returns them to zero.
// - Opcode 35h switches all later commands to four-bit mode.
// - Opcode F5h leaves four-bit mode, only as a two-clock quad command.
// - Suspend 75h/B0h and resume 7Ah/30h work in both command modes.
// - Suspend only hits sector erase, block erase or page program; ignored in chip erase and info row program.
// - During erase suspend, status writes and erases are refused.
// - During program suspend, status writes and programs are refused.
// - Suspend sets the erase or program suspended flag and clears the latch.
// - Resume restarts the operation and clears the suspended flag.
// - While suspended reads, register reads, resume, IDs, no-op and resets are taken.
// - Write-in-progress reads one while an operation runs, zero when done.
module fwqs_ctrl import fwqs_pkg::*; #(
  parameter logic [7:0] INFO_ROW_PROG_OPC = 8'h62
) (
  // Core clock, reset and enable
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Serial link
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe_n,
  // Internal sequencer
  output logic o_op_start,
  output fwqs_op_t o_op_kind,
  output logic o_op_suspend,
  output logic o_op_resume,
  input wire logic i_op_done,
  input wire logic i_suspend_ready,
  // Status bits
  output logic o_write_enable_latch,
  output logic o_write_in_progress,
  output logic o_quad_command_mode,
  output logic [3:0] o_block_protect_bits,
  output logic o_status_write_protect,
  output logic o_quad_io_enable,
  output logic o_bottom_area_select,
  output logic [3:0] o_info_row_lock_bits,
  output logic o_program_suspended_flag,
  output logic o_erase_suspended_flag
);

  // Core state
  fwqs_state_t state_q, state_d;
  fwqs_op_t kind_q, kind_d;
  logic write_enable_latch_q, write_enable_latch_d;
  logic quad_mode_q, quad_mode_d;
  logic [3:0] block_protect_q, block_protect_d;
  logic status_write_protect_q, status_write_protect_d;
  logic quad_io_enable_q, quad_io_enable_d;
  logic bottom_area_q, bottom_area_d;
  logic [3:0] info_row_lock_q, info_row_lock_d;
  logic program_susp_q, program_susp_d;
  logic erase_susp_q, erase_susp_d;
  logic start_q, start_d;
  logic suspend_q, suspend_d;
  logic resume_q, resume_d;
  logic cs_prev_q;
  logic [7:0] status_shadow_q;
  logic [7:0] function_shadow_q;

  // Link state
  logic started_q;
  logic [5:0] cnt_q;
  logic [15:0] sh_q;
  logic [7:0] opc_q;
  logic rd_load_q;
  logic [7:0] rd_byte_q;
  logic [7:0] out_q;
  logic [3:0] oe_n_q;

  // Frame decode wires
  logic cs_sync;
  logic frame_end;
  logic [5:0] len_cmd;
  logic is_cmd_len;
  logic is_data_len;
  logic is_addr_len;
  logic [7:0] opc;
  logic [7:0] data_byte;
  logic allowed;
  logic writable;
  logic [7:0] status_now;
  logic [7:0] function_now;
  logic [5:0] cnt_next;
  logic [15:0] sh_next;
  logic opc_complete;

  // Chip select into the core domain
  fwqs_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b1)
  ) u_cs_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_async(i_cs_n),
    .o_sync(cs_sync)
  );

  // Frame marker, cleared as soon as chip select goes high
  always_ff @(posedge i_sck or posedge i_cs_n or negedge i_nrst) begin
    if (!i_nrst) begin
      started_q <= 1'b0;
    end else if (i_cs_n) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  // Shift in one bit or one nibble per clock; the count saturates
  assign cnt_next = !started_q ? 6'h01 : ((cnt_q == LEN_SATURATE) ? cnt_q : cnt_q + 6'h01);
  assign sh_next = quad_mode_q ? {sh_q[11:0], i_io} : {sh_q[14:0], i_io[0]};
  assign opc_complete = (cnt_next == len_cmd);

  // Capture stays frozen after chip select rises, for the core to read
  always_ff @(posedge i_sck or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= '0;
      opc_q <= '0;
      sh_q <= '0;
      rd_load_q <= 1'b0;
      rd_byte_q <= '0;
    end else if (!i_cs_n) begin
      cnt_q <= cnt_next;
      sh_q <= sh_next;
      opc_q <= opc_complete ? sh_next[7:0] : opc_q;
      rd_load_q <= opc_complete && ((sh_next[7:0] == OPC_STATUS_READ_CMD) ||
                                    (sh_next[7:0] == OPC_FUNCTION_REG_READ_CMD));
      rd_byte_q <= (sh_next[7:0] == OPC_STATUS_READ_CMD) ? status_shadow_q : function_shadow_q;
    end
  end

  // Read data out on falling edges; the byte rotates so it repeats
  always_ff @(negedge i_sck or posedge i_cs_n or negedge i_nrst) begin
    if (!i_nrst) begin
      out_q <= '0;
      oe_n_q <= 4'hF;
    end else if (i_cs_n) begin
      out_q <= '0;
      oe_n_q <= 4'hF;
    end else if (rd_load_q) begin
      out_q <= rd_byte_q;
      oe_n_q <= quad_mode_q ? 4'h0 : 4'hD;
    end else if (oe_n_q != 4'hF) begin
      out_q <= quad_mode_q ? {out_q[3:0], out_q[7:4]} : {out_q[6:0], out_q[7]};
    end
  end

  // Pin drive: single mode on IO1, quad mode on all four
  assign o_io = quad_mode_q ? out_q[7:4] : {2'b00, out_q[7], 1'b0};
  assign o_io_oe_n = oe_n_q;

  // Frame end and what it carried
  assign frame_end = cs_sync && !cs_prev_q;
  assign len_cmd = quad_mode_q ? LEN_CMD_QUAD : LEN_CMD_SINGLE;
  assign is_cmd_len = (cnt_q == len_cmd);
  assign is_data_len = (cnt_q == (quad_mode_q ? LEN_DATA_QUAD : LEN_DATA_SINGLE));
  assign is_addr_len = (cnt_q >= (quad_mode_q ? LEN_ADDR_QUAD : LEN_ADDR_SINGLE));
  assign opc = opc_q;
  assign data_byte = sh_q[7:0];

  // Suspend allow list lookup
  always_comb begin
    allowed = 1'b0;
    for (int i = 0; i < ALLOW_COUNT; i++) begin
      if (opc == ALLOW_LIST[i]) begin
        allowed = 1'b1;
      end
    end
  end

  // Conditions for taking a command
  assign writable = (state_q == ST_IDLE) && write_enable_latch_q;

  // Register images
  assign status_now = {status_write_protect_q, quad_io_enable_q, block_protect_q,
                       write_enable_latch_q, (state_q == ST_BUSY) || (state_q == ST_SUSPENDING)};
  assign function_now = {info_row_lock_q, erase_susp_q, program_susp_q, bottom_area_q, 1'b0};

  // Command interpreter
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    write_enable_latch_d = write_enable_latch_q;
    quad_mode_d = quad_mode_q;
    block_protect_d = block_protect_q;
    status_write_protect_d = status_write_protect_q;
    quad_io_enable_d = quad_io_enable_q;
    bottom_area_d = bottom_area_q;
    info_row_lock_d = info_row_lock_q;
    program_susp_d = program_susp_q;
    erase_susp_d = erase_susp_q;
    start_d = 1'b0;
    suspend_d = 1'b0;
    resume_d = 1'b0;
    case (state_q)
      ST_BUSY: begin
        if (i_op_done) begin
          state_d = ST_IDLE;
          kind_d = OP_NONE;
          write_enable_latch_d = 1'b0;
        end else if (frame_end && is_cmd_len &&
                     ((opc == OPC_SUSPEND_CMD_A) || (opc == OPC_SUSPEND_CMD_B)) &&
                     ((kind_q == OP_SECTOR_ERASE) || (kind_q == OP_BLOCK_ERASE) ||
                      (kind_q == OP_PAGE_PROG))) begin
          state_d = ST_SUSPENDING;
          suspend_d = 1'b1;
          write_enable_latch_d = 1'b0;
          erase_susp_d = (kind_q != OP_PAGE_PROG);
          program_susp_d = (kind_q == OP_PAGE_PROG);
        end
      end
      ST_SUSPENDING: begin
        if (i_suspend_ready) begin
          state_d = ST_SUSPENDED;
        end
      end
      ST_SUSPENDED: begin
        // Anything outside the allow list falls through untouched
        if (frame_end && is_cmd_len && allowed &&
            ((opc == OPC_RESUME_CMD_A) || (opc == OPC_RESUME_CMD_B))) begin
          state_d = ST_BUSY;
          resume_d = 1'b1;
          erase_susp_d = 1'b0;
          program_susp_d = 1'b0;
        end
      end
      ST_IDLE: begin
        if (frame_end && is_cmd_len) begin
          if (opc == OPC_WRITE_ENABLE_CMD) begin
            write_enable_latch_d = 1'b1;
          end else if (opc == OPC_WRITE_DISABLE_CMD) begin
            write_enable_latch_d = 1'b0;
          end else if (((opc == OPC_FULL_ARRAY_ERASE_A) || (opc == OPC_FULL_ARRAY_ERASE_B)) &&
                       writable) begin
            state_d = ST_BUSY;
            kind_d = OP_CHIP_ERASE;
            start_d = 1'b1;
          end else if ((opc == OPC_QUAD_MODE_ENTRY_CMD) && !quad_mode_q) begin
            quad_mode_d = 1'b1;
          end else if ((opc == OPC_QUAD_MODE_EXIT_CMD) && quad_mode_q) begin
            quad_mode_d = 1'b0;
          end
        end else if (frame_end && is_data_len && writable) begin
          if (opc == OPC_STATUS_WRITE_CMD) begin
            block_protect_d = data_byte[ST_BP_LSB +: 4];
            quad_io_enable_d = data_byte[ST_QIO_POS];
            status_write_protect_d = data_byte[ST_SWP_POS];
            state_d = ST_BUSY;
            kind_d = OP_STATUS_WRITE;
            start_d = 1'b1;
          end else if (opc == OPC_FUNCTION_REG_WRITE_CMD) begin
            bottom_area_d = bottom_area_q | data_byte[FN_BOTTOM_POS];
            info_row_lock_d = info_row_lock_q | data_byte[FN_IRL_LSB +: 4];
            state_d = ST_BUSY;
            kind_d = OP_FUNC_WRITE;
            start_d = 1'b1;
          end
        end else if (frame_end && is_addr_len && writable) begin
          // Address-carrying erases and programs; refused while suspended
          if ((opc == OPC_SECTOR_ERASE_A) || (opc == OPC_SECTOR_ERASE_B)) begin
            state_d = ST_BUSY;
            kind_d = OP_SECTOR_ERASE;
            start_d = 1'b1;
          end else if ((opc == OPC_BLOCK_ERASE_32K) || (opc == OPC_BLOCK_ERASE_64K)) begin
            state_d = ST_BUSY;
            kind_d = OP_BLOCK_ERASE;
            start_d = 1'b1;
          end else if ((opc == OPC_PAGE_PROG) || (opc == OPC_PAGE_PROG_QUAD_A) ||
                       (opc == OPC_PAGE_PROG_QUAD_B)) begin
            state_d = ST_BUSY;
            kind_d = OP_PAGE_PROG;
            start_d = 1'b1;
          end else if (opc == INFO_ROW_PROG_OPC) begin
            state_d = ST_BUSY;
            kind_d = OP_INFO_PROG;
            start_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Core registers
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
      kind_q <= OP_NONE;
      write_enable_latch_q <= 1'b0;
      quad_mode_q <= 1'b0;
      block_protect_q <= RST_BLOCK_PROTECT;
      status_write_protect_q <= RST_STATUS_WRITE_PROTECT;
      quad_io_enable_q <= RST_QUAD_IO_ENABLE;
      bottom_area_q <= RST_BOTTOM_AREA;
      info_row_lock_q <= RST_INFO_ROW_LOCK;
      program_susp_q <= 1'b0;
      erase_susp_q <= 1'b0;
      start_q <= 1'b0;
      suspend_q <= 1'b0;
      resume_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else if (i_ce) begin
      state_q <= state_d;
      kind_q <= kind_d;
      write_enable_latch_q <= write_enable_latch_d;
      quad_mode_q <= quad_mode_d;
      block_protect_q <= block_protect_d;
      status_write_protect_q <= status_write_protect_d;
      quad_io_enable_q <= quad_io_enable_d;
      bottom_area_q <= bottom_area_d;
      info_row_lock_q <= info_row_lock_d;
      program_susp_q <= program_susp_d;
      erase_susp_q <= erase_susp_d;
      start_q <= start_d;
      suspend_q <= suspend_d;
      resume_q <= resume_d;
      cs_prev_q <= cs_sync;
    end
  end

  // Read images, refreshed only between frames so the link sees them still
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      status_shadow_q <= '0;
      function_shadow_q <= '0;
    end else if (i_ce && cs_sync) begin
      status_shadow_q <= status_now;
      function_shadow_q <= function_now;
    end
  end

  // Sequencer and status outputs
  assign o_op_start = start_q;
  assign o_op_kind = kind_q;
  assign o_op_suspend = suspend_q;
  assign o_op_resume = resume_q;
  assign o_write_enable_latch = write_enable_latch_q;
  assign o_write_in_progress = status_now[ST_WIP_POS];
  assign o_quad_command_mode = quad_mode_q;
  assign o_block_protect_bits = block_protect_q;
  assign o_status_write_protect = status_write_protect_q;
  assign o_quad_io_enable = quad_io_enable_q;
  assign o_bottom_area_select = bottom_area_q;
  assign o_info_row_lock_bits = info_row_lock_q;
  assign o_program_suspended_flag = program_susp_q;
  assign o_erase_suspended_flag = erase_susp_q;

endmodule : fwqs_ctrl

/* File: core/fwqs_pkg.sv */
package fwqs_pkg;

  // Command opcodes
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] OPC_STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OPC_FUNCTION_REG_READ_CMD = 8'h48;
  localparam logic [7:0] OPC_FUNCTION_REG_WRITE_CMD = 8'h42;
  localparam logic [7:0] OPC_FULL_ARRAY_ERASE_A = 8'hC7;
  localparam logic [7:0] OPC_FULL_ARRAY_ERASE_B = 8'h60;
  localparam logic [7:0] OPC_QUAD_MODE_ENTRY_CMD = 8'h35;
  localparam logic [7:0] OPC_QUAD_MODE_EXIT_CMD = 8'hF5;
  localparam logic [7:0] OPC_SUSPEND_CMD_A = 8'h75;
  localparam logic [7:0] OPC_SUSPEND_CMD_B = 8'hB0;
  localparam logic [7:0] OPC_RESUME_CMD_A = 8'h7A;
  localparam logic [7:0] OPC_RESUME_CMD_B = 8'h30;
  localparam logic [7:0] OPC_SECTOR_ERASE_A = 8'hD7;
  localparam logic [7:0] OPC_SECTOR_ERASE_B = 8'h20;
  localparam logic [7:0] OPC_BLOCK_ERASE_32K = 8'h52;
  localparam logic [7:0] OPC_BLOCK_ERASE_64K = 8'hD8;
  localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
  localparam logic [7:0] OPC_PAGE_PROG_QUAD_A = 8'h32;
  localparam logic [7:0] OPC_PAGE_PROG_QUAD_B = 8'h38;

  // Commands still taken while suspended
  localparam int ALLOW_COUNT = 24;
  localparam logic [7:0] ALLOW_LIST [ALLOW_COUNT] = '{
    8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED, 8'h05, 8'h48, 8'h7A,
    8'h30, 8'hAB, 8'hC0, 8'h9F, 8'h90, 8'hAF, 8'h4B, 8'h5A, 8'h00, 8'h66, 8'h99, 8'h68
  };

  // Frame lengths in link clocks
  localparam logic [5:0] LEN_CMD_SINGLE = 6'h08;
  localparam logic [5:0] LEN_CMD_QUAD = 6'h02;
  localparam logic [5:0] LEN_DATA_SINGLE = 6'h10;
  localparam logic [5:0] LEN_DATA_QUAD = 6'h04;
  localparam logic [5:0] LEN_ADDR_SINGLE = 6'h20;
  localparam logic [5:0] LEN_ADDR_QUAD = 6'h08;
  localparam logic [5:0] LEN_SATURATE = 6'h3F;

  // Status register field positions
  localparam int ST_WIP_POS = 0;
  localparam int ST_WEL_POS = 1;
  localparam int ST_BP_LSB = 2;
  localparam int ST_QIO_POS = 6;
  localparam int ST_SWP_POS = 7;

  // Function register field positions
  localparam int FN_BOTTOM_POS = 1;
  localparam int FN_PROGRAM_SUSPENDED_FLAG_POS = 2;
  localparam int FN_ERASE_SUSPENDED_FLAG_POS = 3;
  localparam int FN_IRL_LSB = 4;

  // Power-up values of the nonvolatile fields
  localparam logic [3:0] RST_BLOCK_PROTECT = 4'h0;
  localparam logic RST_STATUS_WRITE_PROTECT = 1'b0;
  localparam logic RST_QUAD_IO_ENABLE = 1'b0;
  localparam logic RST_BOTTOM_AREA = 1'b0;
  localparam logic [3:0] RST_INFO_ROW_LOCK = 4'h0;

  // Host-side timing, in ns, and the matching core clock counts
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int SUSPEND_READY_TIME_NS = 100000;
  localparam int RESUME_TO_SUSPEND_TIME_NS = 80000;
  localparam int SUSPEND_READY_CYCLES = SUSPEND_READY_TIME_NS / CLOCK_PERIOD_NS;
  localparam int RESUME_TO_SUSPEND_CYCLES = RESUME_TO_SUSPEND_TIME_NS / CLOCK_PERIOD_NS;

  // Internal operation handed to the sequencer
  typedef enum logic [2:0] {
    OP_NONE,
    OP_CHIP_ERASE,
    OP_SECTOR_ERASE,
    OP_BLOCK_ERASE,
    OP_PAGE_PROG,
    OP_INFO_PROG,
    OP_STATUS_WRITE,
    OP_FUNC_WRITE
  } fwqs_op_t;

  // Core control state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY,
    ST_SUSPENDING,
    ST_SUSPENDED
  } fwqs_state_t;

endpackage : fwqs_pkg

/* File: core/fwqs_sync.sv */
`timescale 1ns/1ps
module fwqs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Level in and out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Two flops; the first is read only by the second
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= RESET_VALUE;
      sync_q <= RESET_VALUE;
    end else if (i_ce) begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : fwqs_sync

/* File: sim/fwqs_assertions.sv */
`timescale 1ns/1ps
module fwqs_assertions import fwqs_pkg::*; (
  // Clock, reset and select
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  // Sequencer and state
  input wire logic i_op_done,
  input wire logic o_op_start,
  input wire fwqs_op_t o_op_kind,
  input wire logic o_op_suspend,
  input wire logic o_op_resume,
  input wire logic o_write_enable_latch,
  input wire logic o_write_in_progress,
  input wire logic o_quad_command_mode,
  input wire logic [3:0] o_io_oe_n,
  input wire logic o_bottom_area_select,
  input wire logic [3:0] o_info_row_lock_bits,
  input wire logic o_program_suspended_flag,
  input wire logic o_erase_suspended_flag
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  // Sequencer finishing a running operation
  sequence busy_done_s;
    i_op_done && o_write_in_progress && !o_erase_suspended_flag && !o_program_suspended_flag;
  endsequence
  // Select high at this edge and two edges before
  sequence cs_quiet_s;
    i_cs_n && $past(i_cs_n, 2);
  endsequence

  chk_wel_powerup: assert property ($rose(i_nrst) |-> !o_write_enable_latch)
    else $error("latch set after reset");
  chk_start_framed: assert property (o_op_start |-> cs_quiet_s)
    else $error("start inside a frame");
  chk_start_latch: assert property (o_op_start |-> $past(o_write_enable_latch) && o_write_in_progress)
    else $error("start without latch or busy");
  chk_done_clears: assert property (busy_done_s |=> !o_write_enable_latch && !o_write_in_progress && o_op_kind == OP_NONE)
    else $error("done did not clear");
  chk_erase_suspended_flag_cause: assert property ($rose(o_erase_suspended_flag) |->
    o_op_kind inside {OP_SECTOR_ERASE, OP_BLOCK_ERASE} && !o_write_enable_latch)
    else $error("bad erase suspend");
  chk_program_suspended_flag_cause: assert property ($rose(o_program_suspended_flag) |->
    o_op_kind == OP_PAGE_PROG && !o_write_enable_latch)
    else $error("bad program suspend");
  chk_suspend_flags: assert property (o_op_suspend |-> ##[0:1] (o_erase_suspended_flag || o_program_suspended_flag))
    else $error("suspend without flag");
  chk_no_start_held: assert property ((o_erase_suspended_flag || o_program_suspended_flag) |-> !o_op_start)
    else $error("start while suspended");
  chk_resume_clears: assert property (o_op_resume |->
    ##[0:1] (!o_erase_suspended_flag && !o_program_suspended_flag && o_write_in_progress))
    else $error("resume left flag");
  chk_otp_sticky: assert property (!$fell(o_bottom_area_select) &&
    (($past(o_info_row_lock_bits) & ~o_info_row_lock_bits) == 4'h0))
    else $error("lock bit cleared");
  chk_read_drive: assert property ((!i_cs_n && o_io_oe_n != 4'hF) |->
    o_io_oe_n == (o_quad_command_mode ? 4'h0 : 4'hD))
    else $error("drive width wrong");
  chk_mode_framed: assert property (!$stable(o_quad_command_mode) |-> cs_quiet_s)
    else $error("mode changed in frame");
endmodule : fwqs_assertions

bind fwqs_ctrl fwqs_assertions u_fwqs_assertions (.*);

/* File: sim/fwqs_host.sv */
`timescale 1ns/1ps
module fwqs_host (
  // Host pins
  output logic o_sck,
  output logic o_cs_n,
  output logic [3:0] o_io,
  // Pad level
  input wire logic [3:0] i_io
);
  // Deselected, clock parked low
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h5;
  end

  // Frame: n clocks of w from the top, then r read clocks
  task automatic xfer(input logic [31:0] w, input int n, input bit quad, input int r, output logic [15:0] rd);
    rd = 16'h0000;
    o_cs_n = 1'b0;
    #100;
    for (int k = 0; k < n + r; k++) begin
      if (k < n) o_io = quad ? w[31 - 4 * k -: 4] : {3'h0, w[31 - k]};
      else o_io = ~o_io;
      #7.5 o_sck = 1'b1;
      if (k >= n) rd = quad ? {rd[11:0], i_io} : {rd[14:0], i_io[1]};
      #7.5 o_sck = 1'b0;
    end
    #7.5 o_cs_n = 1'b1;
    o_io = ~o_io;
    #150;
  endtask : xfer
endmodule : fwqs_host

/* File: sim/fwqs_ctrl_tb.sv */
`timescale 1ns/1ps
module fwqs_ctrl_tb import fwqs_pkg::*; ;
  // Pins
  logic i_clock = 1'b0;
  logic i_nrst, i_op_done, i_suspend_ready, h_sck, h_cs_n, o_op_start, o_op_suspend, o_op_resume;
  logic o_write_enable_latch, o_write_in_progress, o_quad_command_mode, o_status_write_protect;
  logic o_quad_io_enable, o_bottom_area_select, o_program_suspended_flag, o_erase_suspended_flag;
  logic [3:0] h_io, i_io, o_io, o_io_oe_n, o_block_protect_bits, o_info_row_lock_bits;
  fwqs_op_t o_op_kind, m_kind;
  // Model and counters
  int mismatches, checks, n_start, n_sus, n_res, m_wel, m_q, m_st, m_sr, m_fn, m_start, m_sus, m_res, rnd;
  logic [7:0] ops [4] = '{8'hD7, 8'h02, 8'h52, 8'h02};
  logic [7:0] sus [4] = '{8'h75, 8'hB0, 8'h75, 8'hB0};
  logic [7:0] res [4] = '{8'h7A, 8'h30, 8'h30, 8'h7A};

  fwqs_ctrl u_fwqs_ctrl (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_ce(1'b1), .i_sck(h_sck), .i_cs_n(h_cs_n), .i_io(i_io),
    .o_io(o_io), .o_io_oe_n(o_io_oe_n), .o_op_start(o_op_start), .o_op_kind(o_op_kind),
    .o_op_suspend(o_op_suspend), .o_op_resume(o_op_resume), .i_op_done(i_op_done),
    .i_suspend_ready(i_suspend_ready), .o_write_enable_latch(o_write_enable_latch),
    .o_write_in_progress(o_write_in_progress), .o_quad_command_mode(o_quad_command_mode),
    .o_block_protect_bits(o_block_protect_bits), .o_status_write_protect(o_status_write_protect),
    .o_quad_io_enable(o_quad_io_enable), .o_bottom_area_select(o_bottom_area_select),
    .o_info_row_lock_bits(o_info_row_lock_bits), .o_program_suspended_flag(o_program_suspended_flag),
    .o_erase_suspended_flag(o_erase_suspended_flag)
  );
  fwqs_host u_fwqs_host (.o_sck(h_sck), .o_cs_n(h_cs_n), .o_io(h_io), .i_io(i_io));

  // Core clock and pad level
  always #12.5 i_clock = ~i_clock;
  assign i_io = (o_io & ~o_io_oe_n) | (h_io & o_io_oe_n);
  // Sequencer request pulses counted mid-cycle
  always @(negedge i_clock) begin
    n_start += int'(o_op_start);
    n_sus += int'(o_op_suspend);
    n_res += int'(o_op_resume);
  end

  task automatic end_sim;
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic fwqs_op_t kind_of(input logic [7:0] op);
    case (op)
      8'hC7, 8'h60: return OP_CHIP_ERASE;
      8'hD7, 8'h20: return OP_SECTOR_ERASE;
      8'h52: return OP_BLOCK_ERASE;
      8'h02: return OP_PAGE_PROG;
      8'h62: return OP_INFO_PROG;
      8'h01: return OP_STATUS_WRITE;
      8'h42: return OP_FUNC_WRITE;
      default: return OP_NONE;
    endcase
  endfunction : kind_of

  function automatic int exp_fn();
    return m_fn | (m_st < 2 ? 0 : m_kind == OP_PAGE_PROG ? 4 : 8);
  endfunction : exp_fn

  task automatic check_state;
    chk("latch", 8'(m_wel), {7'h00, o_write_enable_latch});
    chk("busy", 8'(m_st == 1 || m_st == 2), {7'h00, o_write_in_progress});
    chk("quad", 8'(m_q), {7'h00, o_quad_command_mode});
    chk("status", 8'(m_sr), {o_status_write_protect, o_quad_io_enable, o_block_protect_bits, 2'h0});
    chk("function", 8'(exp_fn()), {o_info_row_lock_bits, o_erase_suspended_flag, o_program_suspended_flag,
      o_bottom_area_select, 1'h0});
    chk("kind", 8'(m_kind), {5'h00, o_op_kind});
    chk("starts", 8'(m_start), 8'(n_start));
    chk("suspends", 8'(m_sus), 8'(n_sus));
    chk("resumes", 8'(m_res), 8'(n_res));
  endtask : check_state

  task automatic mdl(input logic [7:0] op, input logic [7:0] d, input int len);
    fwqs_op_t k;
    k = kind_of(op);
    if (len != (k inside {OP_STATUS_WRITE, OP_FUNC_WRITE} ? 16 : k > OP_CHIP_ERASE ? 32 : 8)) return;
    if (m_st == 0 && op == 8'h06) m_wel = 1;
    if (m_st == 0 && op == 8'h04) m_wel = 0;
    if (m_st == 0 && op == 8'h35 && m_q == 0) m_q = 1;
    if (m_st == 0 && op == 8'hF5 && m_q == 1) m_q = 0;
    if (m_st == 1 && op inside {8'h75, 8'hB0} && m_kind inside {OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_PAGE_PROG}) begin
      m_st = 2;
      m_wel = 0;
      m_sus++;
    end
    if (m_st == 3 && op inside {8'h7A, 8'h30}) begin
      m_st = 1;
      m_res++;
    end
    if (m_st == 0 && k != OP_NONE && m_wel == 1) begin
      m_st = 1;
      m_kind = k;
      m_start++;
      if (k == OP_STATUS_WRITE) m_sr = d & 8'hFC;
      if (k == OP_FUNC_WRITE) m_fn = m_fn | (d & 8'hF2);
    end
  endtask : mdl

  task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int len);
    logic [15:0] rd;
    u_fwqs_host.xfer({op, d, 16'h0000}, m_q ? len / 4 : len, m_q != 0, 0, rd);
    mdl(op, d, len);
    check_state;
  endtask : cmd

  task automatic rdreg(input logic [7:0] op);
    logic [15:0] rd;
    int e;
    e = (op == 8'h05) ? (m_sr | m_wel * 2 | int'(m_st == 1 || m_st == 2)) : exp_fn();
    u_fwqs_host.xfer({op, 24'h000000}, m_q ? 2 : 8, m_q != 0, m_q ? 2 : 8, rd);
    chk("read byte", 8'(e), rd[7:0]);
  endtask : rdreg

  // Sequencer pulse: done or parked
  task automatic done(input bit rdy);
    @(negedge i_clock);
    if (rdy) i_suspend_ready = 1'b1;
    else i_op_done = 1'b1;
    @(negedge i_clock);
    i_suspend_ready = 1'b0;
    i_op_done = 1'b0;
    if (rdy && m_st == 2) m_st = 3;
    if (!rdy && m_st == 1) begin
      m_st = 0;
      m_wel = 0;
      m_kind = OP_NONE;
    end
    repeat (2) @(negedge i_clock);
    check_state;
  endtask : done

  // Park after suspend, then wait for busy to drop
  task automatic settle;
    done(1'b1);
    for (int w = 0; o_write_in_progress !== 1'b0; w++) begin
      if (w == 50) begin
        mismatches++;
        end_sim;
      end
      @(negedge i_clock);
    end
    rdreg(8'h05);
  endtask : settle

  initial begin
    i_nrst = 1'b0;
    i_op_done = 1'b0;
    i_suspend_ready = 1'b0;
    m_kind = OP_NONE;
    rnd = $urandom(18);
    repeat (5) @(negedge i_clock);
    i_nrst = 1'b1;
    repeat (3) @(negedge i_clock);
    check_state;
    cmd(8'hC7, 8'h00, 8);
    for (int i = 0; i < 3; i++) begin
      cmd(8'h06, 8'h00, 8);
      if (i == 0) begin
        cmd(8'h04, 8'h00, 8);
        cmd(8'h60, 8'h00, 8);
        cmd(8'h06, 8'h00, 8);
        cmd(8'hC7, 8'h00, 9);
      end
      cmd(i == 2 ? 8'h62 : i ? 8'h60 : 8'hC7, 8'h00, i == 2 ? 32 : 8);
      rdreg(8'h05);
      cmd(8'h75, 8'h00, 8);
      done(1'b0);
    end
    cmd(8'h06, 8'h00, 8);
    cmd(8'h01, 8'($urandom), 16);
    rdreg(8'h05);
    done(1'b0);
    for (int i = 0; i < 2; i++) begin
      cmd(8'h06, 8'h00, 8);
      cmd(8'h42, i ? 8'h00 : 8'($urandom), 16);
      done(1'b0);
      rdreg(8'h48);
    end
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        cmd(8'hF5, 8'h00, 8);
        cmd(8'h35, 8'h00, 8);
        cmd(8'h35, 8'h00, 8);
      end
      cmd(8'h06, 8'h00, 8);
      cmd(ops[i], 8'h00, 32);
      cmd(sus[i], 8'h00, 8);
      rdreg(8'h05);
      settle;
      cmd(8'h06, 8'h00, 8);
      cmd(8'h01, 8'hFF, 16);
      cmd(ops[i], 8'h00, 32);
      rdreg(8'h48);
      cmd(res[i], 8'h00, 8);
      if (i == 0) begin
        repeat (RESUME_TO_SUSPEND_CYCLES) @(negedge i_clock);
        cmd(sus[i], 8'h00, 8);
        settle;
        cmd(res[i], 8'h00, 8);
      end
      done(1'b0);
    end
    cmd(8'hF5, 8'h00, 8);
    end_sim;
  end
endmodule : fwqs_ctrl_tb
